// *** logic/rswc_ctrl.sv ***
//------------------------------------------------------------
// Purpose: reset, sleep and wake-up sequencer for a small core
// Assumes: rstn is the power-on reset; pins and rc tick are async
// Notes: registers on classic wishbone, one word per register
//------------------------------------------------------------
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
module rswc_ctrl #(
  parameter int HOLD_TICKS = rswc_pkg::HOLD_TICKS,
  parameter int WDT_TICKS = rswc_pkg::WDT_TICKS
) (
  input wire logic clock, // 125 mhz system clock
  input wire logic rstn, // power-on reset, sync, low
  input wire logic wbCyc, // wishbone cycle
  input wire logic wbStb, // wishbone strobe
  input wire logic wbWe, // wishbone write
  input wire logic [7:0] wbAdr, // byte address
  input wire logic [3:0] wbSel, // byte selects
  input wire logic [31:0] wbDatI, // write data
  output logic [31:0] wbDatO, // read data
  output logic wbAck, // one-cycle acknowledge
  input wire logic resetPinN, // external reset pin, async
  input wire logic rcOsc, // watchdog rc oscillator, async
  input wire logic [7:0] port6Pins, // port 6 pin levels, async
  input wire logic sleepInstr, // sleep instruction pulse
  input wire logic irqOnInstr, // global irq on pulse
  input wire logic irqOffInstr, // global irq off pulse
  input wire logic wdtClearInstr, // watchdog clear pulse
  output logic coreResetN, // core held in reset, low
  output logic sleepMode, // core asleep
  output logic [7:0] programCounter, // load value for core pc
  output logic pcLoad, // pulse: core loads programCounter
  output logic wakeResume, // pulse: continue after sleep
  output logic [3:0] port5Dir, // 1 = input
  output logic [7:0] port6Dir, // 1 = input
  output logic [7:0] pullDownN, // 0 = pull-down on
  output logic [7:0] pullHighN, // 0 = pull-high on
  output logic [7:0] openDrain, // 1 = open-drain
  output logic [7:0] wakeControl // wake control bits
);

  //----------------------------------------------------------
  // synchronisers and events
  //----------------------------------------------------------
  logic pinMeta_reg, pinSync_reg;
  logic rcMeta_reg, rcSync_reg, rcLast_reg;
  logic [7:0] p6Meta_reg, p6Sync_reg;
  rswc_pkg::rswc_state_e state_reg;
  logic [rswc_pkg::CNT_W-1:0] holdCnt_reg;
  logic [rswc_pkg::CNT_W-1:0] wdtCnt_reg;
  logic [7:0] presc_reg;
  logic [7:0] status_reg, tctl_reg, wdtCtl_reg;
  logic [7:0] iflags_reg, imask_reg, tcc_reg, p6Latch_reg;
  logic globalIrq_reg;
  logic rcEdge, wdtStep, wdtTimeout, pinRst, enterReset;
  logic portChange, portWake, sleepGo, busWr, busRd;
  logic [4:0] busIdx;
  logic [7:0] wrByte, changeBits, rdByte;

  // two flip-flops on each async input: reset pin, rc oscillator, port 6 pins
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      pinMeta_reg <= 1'b1;
      pinSync_reg <= 1'b1;
      rcMeta_reg <= 1'b0;
      rcSync_reg <= 1'b0;
      rcLast_reg <= 1'b0;
      p6Meta_reg <= rswc_pkg::ALL_ZERO;
      p6Sync_reg <= rswc_pkg::ALL_ZERO;
    end
    else
    begin
      pinMeta_reg <= resetPinN;
      pinSync_reg <= pinMeta_reg;
      rcMeta_reg <= rcOsc;
      rcSync_reg <= rcMeta_reg;
      rcLast_reg <= rcSync_reg;
      p6Meta_reg <= port6Pins;
      p6Sync_reg <= p6Meta_reg;
    end
  end
  // prescaler ratio mask from the low three timer control bits
  function automatic logic [7:0] prescMask(input logic [2:0] ratio);
    prescMask = 8'((9'h001 << ratio) - 9'h001);
  endfunction
  // event decode
  always_comb
  begin
    rcEdge = rcSync_reg && !rcLast_reg;
    wdtStep = !tctl_reg[rswc_pkg::TC_PAB] ||
      ((presc_reg & prescMask(tctl_reg[2:0])) == prescMask(tctl_reg[2:0]));
    wdtTimeout = (state_reg != rswc_pkg::ST_HOLD) && wdtCtl_reg[rswc_pkg::WC_EN] && rcEdge && wdtStep &&
      (wdtCnt_reg == rswc_pkg::CNT_W'(WDT_TICKS - 1));
    pinRst = !pinSync_reg;
    enterReset = (state_reg != rswc_pkg::ST_HOLD) && (pinRst || wdtTimeout);
    changeBits = (p6Sync_reg ^ p6Latch_reg) & port6Dir;
    changeBits[0] = changeBits[0] && !wdtCtl_reg[rswc_pkg::WC_EIS];
    portChange = |changeBits;
    portWake = (state_reg == rswc_pkg::ST_SLEEP) && !enterReset && portChange &&
      imask_reg[rswc_pkg::IF_ICIF];
    sleepGo = (state_reg == rswc_pkg::ST_RUN) && sleepInstr && !enterReset;
    busWr = wbCyc && wbStb && wbWe && wbAck && wbSel[0]; // lands at the edge that sees ack
    busRd = wbCyc && wbStb && !wbWe && !wbAck;
    busIdx = wbAdr[6:2];
    wrByte = wbDatI[7:0];
  end

  //----------------------------------------------------------
  // sequencer
  //----------------------------------------------------------
  // run, hold in reset, sleep
  always_ff @(posedge clock)
  begin
    if (!rstn)
      state_reg <= rswc_pkg::ST_HOLD;
    else
    begin
      case (state_reg)
        rswc_pkg::ST_RUN:
        begin
          if (enterReset)
            state_reg <= rswc_pkg::ST_HOLD;
          else if (sleepGo)
            state_reg <= rswc_pkg::ST_SLEEP;
        end
        rswc_pkg::ST_SLEEP:
        begin
          if (enterReset)
            state_reg <= rswc_pkg::ST_HOLD;
          else if (portWake)
            state_reg <= rswc_pkg::ST_RUN;
        end
        rswc_pkg::ST_HOLD:
        begin
          if (!pinRst && rcEdge && holdCnt_reg == rswc_pkg::CNT_W'(HOLD_TICKS - 1))
            state_reg <= rswc_pkg::ST_RUN;
        end
        default:
          state_reg <= rswc_pkg::ST_HOLD;
      endcase
    end
  end
  // hold timer restarts while the pin is still low
  always_ff @(posedge clock)
  begin
    if (!rstn || enterReset || pinRst)
      holdCnt_reg <= '0;
    else if (state_reg == rswc_pkg::ST_HOLD && rcEdge)
      holdCnt_reg <= holdCnt_reg + 1'b1;
  end

  // core-side control outputs
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      coreResetN <= 1'b0;
      sleepMode <= 1'b0;
      pcLoad <= 1'b0;
      wakeResume <= 1'b0;
      programCounter <= rswc_pkg::PC_RESET;
    end
    else
    begin
      coreResetN <= !(enterReset || (state_reg == rswc_pkg::ST_HOLD &&
        !(!pinRst && rcEdge && holdCnt_reg == rswc_pkg::CNT_W'(HOLD_TICKS - 1))));
      sleepMode <= sleepGo || (state_reg == rswc_pkg::ST_SLEEP && !enterReset && !portWake);
      pcLoad <= enterReset || (portWake && globalIrq_reg);
      wakeResume <= portWake && !globalIrq_reg;
      if (enterReset)
        programCounter <= rswc_pkg::PC_RESET;
      else if (portWake && globalIrq_reg)
        programCounter <= rswc_pkg::PC_VECTOR;
      else if (busWr && busIdx == rswc_pkg::IDX_PC)
        programCounter <= wrByte;
    end
  end
  // global interrupt enable, tracked from the core's instructions
  always_ff @(posedge clock)
  begin
    if (!rstn || enterReset)
      globalIrq_reg <= 1'b0;
    else if (irqOnInstr)
      globalIrq_reg <= 1'b1;
    else if (irqOffInstr)
      globalIrq_reg <= 1'b0;
  end

  //----------------------------------------------------------
  // watchdog and prescaler
  //----------------------------------------------------------
  // watchdog keeps counting in sleep, cleared by reset and instructions
  always_ff @(posedge clock)
  begin
    if (!rstn || enterReset || state_reg == rswc_pkg::ST_HOLD)
    begin
      wdtCnt_reg <= '0;
      presc_reg <= rswc_pkg::ALL_ZERO;
    end
    else if ((sleepGo && wdtCtl_reg[rswc_pkg::WC_EN]) || wdtClearInstr)
    begin
      wdtCnt_reg <= '0;
      presc_reg <= rswc_pkg::ALL_ZERO;
    end
    else if (rcEdge)
    begin
      if (tctl_reg[rswc_pkg::TC_PAB])
        presc_reg <= presc_reg + 1'b1;
      if (wdtCtl_reg[rswc_pkg::WC_EN] && wdtStep)
        wdtCnt_reg <= wdtCnt_reg + 1'b1;
    end
  end

  //----------------------------------------------------------
  // registers
  //----------------------------------------------------------
  // status: page bits, time-out and power-down flags
  always_ff @(posedge clock)
  begin
    if (!rstn)
      status_reg <= (8'h01 << rswc_pkg::ST_T) | (8'h01 << rswc_pkg::ST_P);
    else
    begin
      if (busWr && busIdx == rswc_pkg::IDX_STATUS)
        status_reg <= (status_reg & ~rswc_pkg::STATUS_WMASK) | (wrByte & rswc_pkg::STATUS_WMASK);
      if (enterReset)
      begin
        if (pinRst && state_reg == rswc_pkg::ST_SLEEP)
        begin
          status_reg[rswc_pkg::ST_T] <= 1'b1;
          status_reg[rswc_pkg::ST_P] <= 1'b0;
        end
        else if (!pinRst)
        begin
          status_reg[rswc_pkg::ST_T] <= 1'b0;
          if (state_reg == rswc_pkg::ST_SLEEP)
            status_reg[rswc_pkg::ST_P] <= 1'b0;
        end
      end
      else if (portWake || sleepGo)
      begin
        status_reg[rswc_pkg::ST_T] <= 1'b1;
        status_reg[rswc_pkg::ST_P] <= 1'b0;
      end
      else if (wdtClearInstr)
      begin
        status_reg[rswc_pkg::ST_T] <= 1'b1;
        status_reg[rswc_pkg::ST_P] <= 1'b1;
      end
    end
  end

  // timer control and timer counter value
  always_ff @(posedge clock)
  begin
    if (!rstn || enterReset)
    begin
      tctl_reg <= rswc_pkg::TCTL_RESET;
      tcc_reg <= rswc_pkg::ALL_ZERO;
    end
    else if (busWr && busIdx == rswc_pkg::IDX_TCTL)
      tctl_reg <= wrByte;
    else if (busWr && busIdx == rswc_pkg::IDX_TCC)
      tcc_reg <= wrByte;
  end

  // watchdog control; any wake-up re-enables the watchdog
  always_ff @(posedge clock)
  begin
    if (!rstn || enterReset)
      wdtCtl_reg <= 8'h01 << rswc_pkg::WC_EN;
    else if (portWake)
      wdtCtl_reg[rswc_pkg::WC_EN] <= 1'b1;
    else if (busWr && busIdx == rswc_pkg::IDX_WDTCTL)
      wdtCtl_reg <= wrByte & rswc_pkg::WDTCTL_WMASK;
  end

  // pad control: directions, pulls, open-drain, wake control
  always_ff @(posedge clock)
  begin
    if (!rstn || enterReset)
    begin
      port5Dir <= rswc_pkg::DIR5_RESET;
      port6Dir <= rswc_pkg::ALL_ONES;
      wakeControl <= rswc_pkg::ALL_ONES;
      pullDownN <= rswc_pkg::ALL_ONES;
      pullHighN <= rswc_pkg::ALL_ONES;
      openDrain <= rswc_pkg::ALL_ZERO;
    end
    else if (busWr)
    begin
      case (busIdx)
        rswc_pkg::IDX_DIR5: port5Dir <= wrByte[3:0];
        rswc_pkg::IDX_DIR6: port6Dir <= wrByte;
        rswc_pkg::IDX_WAKE: wakeControl <= wrByte;
        rswc_pkg::IDX_PULLDN: pullDownN <= wrByte;
        rswc_pkg::IDX_PULLHI: pullHighN <= wrByte;
        rswc_pkg::IDX_ODRAIN: openDrain <= wrByte;
        default: ;
      endcase
    end
  end

  // interrupt enables
  always_ff @(posedge clock)
  begin
    if (!rstn || enterReset)
      imask_reg <= rswc_pkg::ALL_ZERO;
    else if (busWr && busIdx == rswc_pkg::IDX_IMASK)
      imask_reg <= wrByte & rswc_pkg::IRQ_BITS;
  end

  // interrupt flags; a port change wins over a clearing write
  always_ff @(posedge clock)
  begin
    if (!rstn || enterReset)
      iflags_reg <= rswc_pkg::ALL_ZERO;
    else
    begin
      if (busWr && busIdx == rswc_pkg::IDX_IFLAGS)
        iflags_reg <= wrByte & rswc_pkg::IRQ_BITS;
      if (portChange && state_reg != rswc_pkg::ST_HOLD)
        iflags_reg[rswc_pkg::IF_ICIF] <= 1'b1;
    end
  end

  // port 6 reference level, taken on each read of port 6
  always_ff @(posedge clock)
  begin
    if (!rstn)
      p6Latch_reg <= rswc_pkg::ALL_ZERO;
    else if (enterReset || (busRd && busIdx == rswc_pkg::IDX_PORT6))
      p6Latch_reg <= p6Sync_reg;
  end

  //----------------------------------------------------------
  // wishbone slave
  //----------------------------------------------------------
  // read mux; unmapped words read as zero
  always_comb
  begin
    case (busIdx)
      rswc_pkg::IDX_TCC: rdByte = tcc_reg;
      rswc_pkg::IDX_PC: rdByte = programCounter;
      rswc_pkg::IDX_STATUS: rdByte = status_reg;
      rswc_pkg::IDX_PORT6: rdByte = p6Sync_reg;
      rswc_pkg::IDX_WAKE: rdByte = wakeControl;
      rswc_pkg::IDX_PULLDN: rdByte = pullDownN;
      rswc_pkg::IDX_ODRAIN: rdByte = openDrain;
      rswc_pkg::IDX_PULLHI: rdByte = pullHighN;
      rswc_pkg::IDX_WDTCTL: rdByte = wdtCtl_reg;
      rswc_pkg::IDX_IFLAGS: rdByte = iflags_reg;
      rswc_pkg::IDX_IMASK: rdByte = imask_reg;
      rswc_pkg::IDX_DIR5: rdByte = {4'h0, port5Dir};
      rswc_pkg::IDX_DIR6: rdByte = port6Dir;
      rswc_pkg::IDX_TCTL: rdByte = tctl_reg;
      rswc_pkg::IDX_STATE: rdByte = {6'h00, state_reg};
      default: rdByte = rswc_pkg::ALL_ZERO;
    endcase
  end

  // one-cycle acknowledge, data registered with it
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      wbAck <= 1'b0;
      wbDatO <= 32'h00000000;
    end
    else
    begin
      wbAck <= wbCyc && wbStb && !wbAck;
      wbDatO <= busRd ? {24'h000000, rdByte} : 32'h00000000;
    end
  end

endmodule

// *** logic/rswc_pkg.sv ***
//------------------------------------------------------------
// Purpose: constants for the reset and sleep/wake sequencer
// Assumes: classic wishbone, word index = byte address / 4
// Notes: all timing is counted in watchdog rc ticks
//------------------------------------------------------------
package rswc_pkg;
  // timing
  localparam int HOLD_TIME_NS = 18000000; // start-up hold, 18 ms
  localparam int WDT_TIME_NS = 18000000; // watchdog period, 18 ms
  localparam int RC_TICK_NS = 1000; // rc oscillator period, plain default
  localparam int HOLD_TICKS = HOLD_TIME_NS / RC_TICK_NS;
  localparam int WDT_TICKS = WDT_TIME_NS / RC_TICK_NS;
  localparam int CNT_W = 24;

  // register word indexes
  localparam logic [4:0] IDX_TCC = 5'h01;
  localparam logic [4:0] IDX_PC = 5'h02;
  localparam logic [4:0] IDX_STATUS = 5'h03;
  localparam logic [4:0] IDX_PORT6 = 5'h06;
  localparam logic [4:0] IDX_WAKE = 5'h0a;
  localparam logic [4:0] IDX_PULLDN = 5'h0b;
  localparam logic [4:0] IDX_ODRAIN = 5'h0c;
  localparam logic [4:0] IDX_PULLHI = 5'h0d;
  localparam logic [4:0] IDX_WDTCTL = 5'h0e;
  localparam logic [4:0] IDX_IFLAGS = 5'h0f;
  localparam logic [4:0] IDX_IMASK = 5'h11;
  localparam logic [4:0] IDX_DIR5 = 5'h12;
  localparam logic [4:0] IDX_DIR6 = 5'h13;
  localparam logic [4:0] IDX_TCTL = 5'h14;
  localparam logic [4:0] IDX_STATE = 5'h15;

  // reset values and the wake vector
  localparam logic [7:0] PC_RESET = 8'h00;
  localparam logic [7:0] PC_VECTOR = 8'h08;
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [7:0] ALL_ZERO = 8'h00;
  localparam logic [7:0] TCTL_RESET = 8'hbf;
  localparam logic [3:0] DIR5_RESET = 4'hf;

  // field positions
  localparam int ST_T = 4; // time-out flag
  localparam int ST_P = 3; // power-down flag
  localparam int ST_PAGE_LO = 5; // page select bits 7..5
  localparam int WC_EN = 7; // watchdog enable
  localparam int WC_EIS = 6; // external interrupt select
  localparam int WC_ROC = 4; // r-option
  localparam int TC_PAB = 3; // prescaler to watchdog
  localparam int IF_ICIF = 1; // port change flag / enable
  localparam logic [7:0] IRQ_BITS = 8'h07;
  localparam logic [7:0] STATUS_WMASK = 8'he7;
  localparam logic [7:0] WDTCTL_WMASK = 8'hd0;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HOLD = 2'b01,
    ST_SLEEP = 2'b10
  } rswc_state_e;
endpackage

// *** testbench/rswc_ctrl_properties.sv ***
// Purpose: port checks for the reset and sleep sequencer
// Assumes: only top-level ports of rswc_ctrl are visible
// Notes: rc edges are counted here to bound the hold time
`timescale 1ns/1ps
module rswc_ctrl_properties #(
  parameter int HOLD_TICKS = 8,
  parameter int WDT_TICKS = 8
) (
  input wire logic clock, // system clock
  input wire logic rstn, // power-on reset, low
  input wire logic wbCyc, // bus cycle
  input wire logic wbStb, // bus strobe
  input wire logic [31:0] wbDatO, // read data
  input wire logic wbAck, // acknowledge
  input wire logic resetPinN, // reset pin, low
  input wire logic rcOsc, // rc oscillator
  input wire logic sleepInstr, // sleep pulse
  input wire logic coreResetN, // core reset, low
  input wire logic sleepMode, // asleep
  input wire logic [7:0] programCounter, // pc load value
  input wire logic pcLoad, // pc load pulse
  input wire logic wakeResume, // resume pulse
  input wire logic [3:0] port5Dir, // port 5 direction
  input wire logic [7:0] port6Dir, // port 6 direction
  input wire logic [7:0] openDrain // open-drain control
);
  // ----------------------------------------
  // rc tick counter over the hold period
  // ----------------------------------------
  logic rcQ;
  int ticks;
  always_ff @(posedge clock)
  begin
    rcQ <= rcOsc;
  end
  // restarts while the pin is low or the core runs
  always_ff @(posedge clock)
  begin
    if (!rstn || !resetPinN || coreResetN)
      ticks <= 0;
    else if (rcOsc && !rcQ)
      ticks <= ticks + 1;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_req;
    wbCyc && wbStb && !wbAck;
  endsequence
  sequence s_nap;
    sleepInstr && coreResetN && !sleepMode;
  endsequence
  sequence s_resume;
    $fell(sleepMode) && coreResetN;
  endsequence
  a_ack_follows: assert property (s_req |=> wbAck)
    else $error("request without acknowledge");
  a_ack_single: assert property (wbAck |=> !wbAck)
    else $error("acknowledge longer than one cycle");
  a_data_idle: assert property (!wbAck |-> wbDatO == 32'h0)
    else $error("read data outside acknowledge");
  a_sleep_entry: assert property (s_nap |=> sleepMode)
    else $error("sleep not entered");
  a_reset_vector: assert property ($fell(coreResetN) |-> pcLoad && programCounter == 8'h00)
    else $error("reset without zero pc load");
  a_reset_inputs: assert property ($fell(coreResetN) |=> port6Dir == 8'hff && port5Dir == 4'hf && openDrain == 8'h00)
    else $error("pins not released on reset");
  a_wake_branch: assert property (s_resume |-> (pcLoad && programCounter == 8'h08) != wakeResume)
    else $error("wake outcome wrong");
  a_pin_reset: assert property (!resetPinN [*4] |=> !coreResetN)
    else $error("pin low without reset");
  a_hold_length: assert property ($rose(coreResetN) |-> ticks >= HOLD_TICKS - 1 && ticks <= HOLD_TICKS + 1)
    else $error("hold period wrong length");
endmodule
bind rswc_ctrl rswc_ctrl_properties #(.HOLD_TICKS(HOLD_TICKS), .WDT_TICKS(WDT_TICKS)) chk (.clock(clock),
  .rstn(rstn), .wbCyc(wbCyc), .wbStb(wbStb), .wbDatO(wbDatO), .wbAck(wbAck), .resetPinN(resetPinN),
  .rcOsc(rcOsc), .sleepInstr(sleepInstr), .coreResetN(coreResetN), .sleepMode(sleepMode),
  .programCounter(programCounter), .pcLoad(pcLoad), .wakeResume(wakeResume), .port5Dir(port5Dir),
  .port6Dir(port6Dir), .openDrain(openDrain));

// *** testbench/rswc_ctrl_test.sv ***
// Purpose: self-checking bench for the sequencer
// Assumes: short hold and watchdog counts of 8 rc ticks
// Notes: a register model is compared at every result
`timescale 1ns/1ps
module rswc_ctrl_test;
  logic clock = 1'b0;
  logic rstn, wbCyc, wbStb, wbWe, wbAck, resetPinN, rcOsc, pinLowReq;
  logic sleepInstr, irqOnInstr, irqOffInstr, wdtClearInstr, coreResetN, sleepMode, pcLoad, wakeResume;
  logic [3:0] wbSel, port5Dir;
  logic [31:0] wbDatI, wbDatO;
  logic [7:0] wbAdr, port6Pins, levelReq, programCounter, port6Dir, pullDownN, pullHighN, openDrain, wakeControl;
  logic [7:0] mdl [0:31];
  logic [7:0] st;
  logic [4:0] rIdx [14] = '{5'h01, 5'h02, 5'h03, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h11, 5'h12, 5'h13,
    5'h14, 5'h1f};
  logic [4:0] wIdx [9] = '{5'h01, 5'h02, 5'h03, 5'h0b, 5'h0c, 5'h0d, 5'h12, 5'h13, 5'h14};
  int n_mismatch = 0;
  int checks = 0;
  always #4 clock = ~clock;
  rswc_ctrl #(.HOLD_TICKS(8), .WDT_TICKS(8)) DUT (.clock(clock), .rstn(rstn), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck),
    .resetPinN(resetPinN), .rcOsc(rcOsc), .port6Pins(port6Pins), .sleepInstr(sleepInstr),
    .irqOnInstr(irqOnInstr), .irqOffInstr(irqOffInstr), .wdtClearInstr(wdtClearInstr), .coreResetN(coreResetN),
    .sleepMode(sleepMode), .programCounter(programCounter), .pcLoad(pcLoad), .wakeResume(wakeResume),
    .port5Dir(port5Dir), .port6Dir(port6Dir), .pullDownN(pullDownN), .pullHighN(pullHighN),
    .openDrain(openDrain), .wakeControl(wakeControl));
  rswc_far_side far (.clock(clock), .pinLowReq(pinLowReq), .levelReq(levelReq), .resetPinN(resetPinN),
    .rcOsc(rcOsc), .port6Pins(port6Pins));
  // ----------------------------------------
  // compare, bus and model tasks
  // ----------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h0, got}, {7'h0, exp});
  endtask
  // one classic cycle, held until ack is sampled
  task automatic bus(input logic we, input logic [4:0] idx, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    {wbCyc, wbStb, wbWe} <= {2'b11, we};
    wbAdr <= {1'b0, idx, 2'b00};
    wbDatI <= {24'h0, d};
    @(posedge clock);
    while (wbAck !== 1'b1 && n < 20)
    begin
      @(posedge clock);
      n++;
    end
    chk1(wbAck, 1'b1);
    q = wbDatO[7:0];
    {wbCyc, wbStb} <= 2'b00;
    @(posedge clock);
  endtask
  // write and track the model, status flags are read-only
  task automatic wr(input logic [4:0] i, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, i, d, q);
    case (i)
      5'h03: mdl[i] = (mdl[i] & 8'h18) | (d & 8'he7);
      5'h0e: mdl[i] = d & 8'hd0;
      5'h0f, 5'h11: mdl[i] = d & 8'h07;
      5'h12: mdl[i] = d & 8'h0f;
      default: mdl[i] = d;
    endcase
  endtask
  task automatic rd_chk(input logic [4:0] i);
    logic [7:0] q;
    bus(1'b0, i, 8'h00, q);
    chk8(q, mdl[i]);
  endtask
  task automatic check_all;
    foreach (rIdx[i]) rd_chk(rIdx[i]);
    chk8(port6Dir, mdl[5'h13]);
    chk8({4'h0, port5Dir}, mdl[5'h12]);
    chk8(pullDownN, mdl[5'h0b]);
    chk8(pullHighN, mdl[5'h0d]);
    chk8(openDrain, mdl[5'h0c]);
    chk8(wakeControl, mdl[5'h0a]);
  endtask
  // reset values, with the status given by the cause
  task automatic mdl_reset(input logic [7:0] s);
    mdl = '{default: 8'h00};
    mdl[5'h03] = s;
    {mdl[5'h0a], mdl[5'h0b], mdl[5'h0d], mdl[5'h13]} = 32'hffffffff;
    {mdl[5'h0e], mdl[5'h12], mdl[5'h14]} = 24'h800fbf;
  endtask
  task automatic pulse(input int k);
    {wdtClearInstr, irqOffInstr, irqOnInstr, sleepInstr} <= 4'b0001 << k;
    @(posedge clock);
    {wdtClearInstr, irqOffInstr, irqOnInstr, sleepInstr} <= 4'h0;
    @(posedge clock);
  endtask
  // waits for reset entry, then for the end of the hold
  task automatic wait_hold;
    int n;
    n = 0;
    while (coreResetN !== 1'b0 && n < 3000)
    begin
      @(posedge clock);
      n++;
    end
    while (coreResetN !== 1'b1 && n < 3000)
    begin
      @(posedge clock);
      n++;
    end
    chk1(coreResetN, 1'b1);
  endtask
  task automatic rnd_regs;
    logic [7:0] r;
    foreach (wIdx[i])
    begin
      r = 8'($urandom);
      if (wIdx[i] == 5'h14) r = r & 8'hf7; // keep the prescaler on the timer
      if (wIdx[i] == 5'h13) r = r | 8'h80; // keep the wake pin an input
      wr(wIdx[i], r);
    end
  endtask
  task final_report;
    if (n_mismatch == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    {rstn, wbCyc, wbStb, wbWe, pinLowReq, wbAdr, wbDatI, levelReq} = '0;
    {sleepInstr, irqOnInstr, irqOffInstr, wdtClearInstr} = 4'h0;
    wbSel = 4'h1;
    void'($urandom(25));
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    mdl_reset(8'h18);
    wait_hold;
    check_all;
    wr(5'h0e, 8'h00);
    rnd_regs;
    check_all;
    st = {mdl[5'h03][7:5], 1'b0, mdl[5'h03][3:0]};
    wr(5'h0e, 8'h80);
    wait_hold;
    mdl_reset(st);
    wr(5'h0e, 8'h00);
    check_all;
    pulse(3);
    mdl[5'h03][4:3] = 2'b11;
    rd_chk(5'h03);
    rnd_regs;
    for (int g = 1; g >= 0; g--)
    begin
      rd_chk(5'h06 - 5'h06 + 5'h1f);
      bus(1'b0, 5'h06, 8'h00, st);
      wr(5'h0f, 8'h00);
      wr(5'h11, 8'h02);
      pulse(g == 1 ? 1 : 2);
      pulse(0);
      chk1(sleepMode, 1'b1);
      levelReq <= levelReq ^ 8'h80;
      for (int n = 0; n < 200 && sleepMode === 1'b1; n++) @(posedge clock);
      chk1(pcLoad, g[0]);
      chk1(wakeResume, !g[0]);
      mdl[5'h03][4:3] = 2'b10;
      mdl[5'h0e][7] = 1'b1;
      mdl[5'h0f][1] = 1'b1;
      if (g == 1) mdl[5'h02] = 8'h08;
      rd_chk(5'h0e);
      wr(5'h0e, 8'h00);
      check_all;
    end
    for (int k = 0; k < 2; k++)
    begin
      st = {mdl[5'h03][7:5], k[0], 1'b0, mdl[5'h03][2:0]};
      wr(5'h11, 8'h00);
      wr(5'h0e, k == 1 ? 8'h00 : 8'h80);
      pulse(0);
      pinLowReq <= k[0];
      repeat (5) @(posedge clock);
      pinLowReq <= 1'b0;
      wait_hold;
      mdl_reset(st);
      wr(5'h0e, 8'h00);
      check_all;
    end
    rstn <= 1'b0;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    mdl_reset(8'h18);
    wait_hold;
    check_all;
    final_report;
  end
  // cuts a hang short
  initial
  begin
    #400000;
    n_mismatch++;
    $display("MISMATCH %0t timeout", $time);
    final_report;
  end
endmodule

// *** testbench/rswc_far_side.sv ***
// Purpose: reset pin, rc oscillator and port 6 pin source
// Assumes: requests change just after a rising clock edge
// Notes: rc half period is unrelated to the system clock
`timescale 1ns/1ps
module rswc_far_side (
  input wire logic clock, // system clock
  input wire logic pinLowReq, // hold the reset pin low
  input wire logic [7:0] levelReq, // wanted port 6 levels
  output logic resetPinN, // reset pin, low active
  output logic rcOsc, // free-running rc clock
  output logic [7:0] port6Pins // port 6 levels
);
  // rc oscillator runs free, also while asleep
  initial rcOsc = 1'b0;
  always #43.7 rcOsc = ~rcOsc;
  // pins follow the requests one edge later
  initial
  begin
    resetPinN = 1'b1;
    port6Pins = 8'h00;
  end
  always @(posedge clock)
  begin
    resetPinN <= ~pinLowReq;
    port6Pins <= levelReq;
  end
endmodule
